/* logic/sscc_defs.svh */
// constants of the stereo sampler conversion control: fields, resets, timing
`ifndef SSCC_DEFS_SVH
`define SSCC_DEFS_SVH
`define SSCC_CW_WIDTH 16
`define SSCC_CW_RESET 16'h0000
`define SSCC_CW_ATT_MSB 15
`define SSCC_CW_ATT_LSB 8
`define SSCC_CW_BYPASS 7
`define SSCC_CW_RATE 6
`define SSCC_CW_KEEP_LSB 6
`define SSCC_KW_WIDTH (`SSCC_CW_WIDTH - `SSCC_CW_KEEP_LSB)
`define SSCC_KW_RESET 10'h000
`define SSCC_MCLK_NS 100
`define SSCC_LNK_NS 30
`define SSCC_SETTLE_NS 1500
`define SSCC_SETTLE_CYC ((`SSCC_SETTLE_NS + `SSCC_MCLK_NS - 1) / `SSCC_MCLK_NS)
`define SSCC_SETTLE_LOAD (`SSCC_SETTLE_CYC - 2)
`define SSCC_DCLK_HI_NS 280
`define SSCC_DCLK_HI_CYC (`SSCC_DCLK_HI_NS / `SSCC_LNK_NS)
`define SSCC_HOLD_L_RST 1'h1
`endif

/* logic/sscc_pkg.sv */
// types and helpers shared by the sampler conversion control
`include "sscc_defs.svh"
package sscc_pkg;
    typedef enum logic [1:0] {
        SSCC_ST_IDLE = 2'h0,
        SSCC_ST_SETTLE = 2'h1,
        SSCC_ST_FIRE = 2'h2
    } sscc_st_t;
    typedef struct packed {logic s1; logic s2;} sscc_sync_t;
    typedef struct packed {logic [7:0] cnt; logic q;} sscc_shot_t;
    typedef struct packed {
        logic [`SSCC_CW_WIDTH-1:0] shift;
        logic [`SSCC_KW_WIDTH-1:0] word;
        logic tgl;
        logic sclk_d;
        logic eoc_d;
        logic dout;
        logic eoc_out;
    } sscc_lnk_t;
    typedef struct packed {
        logic tgl_d;
        logic [`SSCC_KW_WIDTH-1:0] word;
        logic [1:0] mode;
        logic conv_d;
        logic half;
        logic sel_d;
        sscc_st_t st;
        logic [4:0] cnt;
        logic start;
        logic osc_div;
        logic [7:0] att;
        logic bypass;
        logic hold_r;
        logic hold_l;
        logic mux_r;
    } sscc_core_t;
    // rising edge seen between a registered copy and the current level
    function automatic logic sscc_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction
endpackage

/* logic/sscc_sync.sv */
// two-flop synchroniser for one asynchronous bit
`timescale 1ns/100ps
module sscc_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    sscc_pkg::sscc_sync_t s_r;
    sscc_pkg::sscc_sync_t s_nxt;
    // the first stage is read by the second stage only
    always_comb begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r.s2;
endmodule // sscc_sync

/* logic/sscc_stretch.sv */
// one-shot that stretches a trigger to a fixed high time
`timescale 1ns/100ps
module sscc_stretch #(
    parameter logic [7:0] LEN = 8'h01
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic trig,
    output logic q
);
    sscc_pkg::sscc_shot_t s_r;
    sscc_pkg::sscc_shot_t s_nxt;
    // not retriggerable: a trigger while high is ignored
    always_comb begin
        s_nxt = s_r;
        if (!s_r.q && trig) begin
            s_nxt.q = 1'h1;
            s_nxt.cnt = LEN - 8'h01;
        end else if (s_r.q) begin
            if (s_r.cnt == 8'h00) begin
                s_nxt.q = 1'h0;
            end else begin
                s_nxt.cnt = s_r.cnt - 8'h01;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r.q;
    AST_SHOT_LOAD: assert property (@(posedge clk) disable iff (rst)
        (trig && !s_r.q) |=> (s_r.q && s_r.cnt == LEN - 8'h01))
        else $error("one-shot did not start with full length");
    AST_SHOT_END: assert property (@(posedge clk) disable iff (rst)
        (s_r.q && s_r.cnt == 8'h00) |=> !s_r.q)
        else $error("one-shot did not end after its length");
endmodule // sscc_stretch

/* logic/sscc_top.sv */
// conversion sequencing, link shifting and control latches of the sampler
`timescale 1ns/100ps
`include "sscc_defs.svh"
module sscc_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic lnk_clk,
    input wire logic conv_clk_pin,
    input wire logic host_sdata_pin,
    input wire logic cvt_sclk_pin,
    input wire logic cvt_sdata_pin,
    input wire logic cvt_eoc_pin,
    output logic data_clk,
    output logic data_out,
    output logic eoc_out,
    output logic cvt_clk,
    output logic conv_start,
    output logic hold_right,
    output logic hold_left,
    output logic mux_right,
    output logic [7:0] gain_atten,
    output logic filter_bypass,
    output logic right_to_both
);
    // pin slots of the link-side synchroniser bank
    localparam int LP_SCLK = 0;
    localparam int LP_SDATA = 1;
    localparam int LP_EOC = 2;
    localparam int LP_HOST = 3;
    localparam int LP_N = 4;
    // slots of the core-side synchroniser bank
    localparam int CP_CONV = 0;
    localparam int CP_TGL = 1;
    localparam int CP_N = 2;
    // settle figure as an int for the checks below
    localparam int SETTLE_I = `SSCC_SETTLE_CYC;
    // kept-word positions of the control fields
    localparam int KW_ATT_MSB = `SSCC_CW_ATT_MSB - `SSCC_CW_KEEP_LSB;
    localparam int KW_ATT_LSB = `SSCC_CW_ATT_LSB - `SSCC_CW_KEEP_LSB;
    localparam int KW_BYPASS = `SSCC_CW_BYPASS - `SSCC_CW_KEEP_LSB;
    localparam int KW_RATE = `SSCC_CW_RATE - `SSCC_CW_KEEP_LSB;

    sscc_pkg::sscc_lnk_t lnk_r;
    sscc_pkg::sscc_lnk_t lnk_nxt;
    sscc_pkg::sscc_core_t core_r;
    sscc_pkg::sscc_core_t core_nxt;
    logic [LP_N-1:0] lp_raw;
    logic [LP_N-1:0] lp_s;
    logic [CP_N-1:0] cp_raw;
    logic [CP_N-1:0] cp_s;
    logic sclk_s;
    logic sdata_s;
    logic eoc_s;
    logic host_s;
    logic conv_s;
    logic tgl_s;
    logic sclk_rise;
    logic eoc_rise;
    logic sel;
    logic sel_rise;
    logic conv_rise;

    // ---------------- link domain ----------------
    // every pin from the converter or the isolated link is asynchronous here
    assign lp_raw[LP_SCLK] = cvt_sclk_pin;
    assign lp_raw[LP_SDATA] = cvt_sdata_pin;
    assign lp_raw[LP_EOC] = cvt_eoc_pin;
    assign lp_raw[LP_HOST] = host_sdata_pin;
    genvar gi;
    generate
        for (gi = 0; gi < LP_N; gi++) begin : g_lnk_sync
            sscc_sync u_sync (
                .clk(lnk_clk),
                .rst(rst),
                .d(lp_raw[gi]),
                .q(lp_s[gi])
            );
        end
    endgenerate
    assign sclk_s = lp_s[LP_SCLK];
    assign sdata_s = lp_s[LP_SDATA];
    assign eoc_s = lp_s[LP_EOC];
    assign host_s = lp_s[LP_HOST];

    // edges of the converter bit clock and of end of conversion
    assign sclk_rise = sscc_pkg::sscc_rise(sclk_s, lnk_r.sclk_d);
    assign eoc_rise = sscc_pkg::sscc_rise(eoc_s, lnk_r.eoc_d);

    // the short last bit pulse is too brief for the link, so every
    // bit pulse is rebuilt as a fixed high time of about half a bit
    sscc_stretch #(
        .LEN(8'(`SSCC_DCLK_HI_CYC))
    ) u_dclk (
        .clk(lnk_clk),
        .rst(rst),
        .trig(sclk_rise),
        .q(data_clk)
    );

    // shift register, result forwarding and end-of-conversion latch
    always_comb begin
        lnk_nxt = lnk_r;
        lnk_nxt.sclk_d = sclk_s;
        lnk_nxt.eoc_d = eoc_s;
        lnk_nxt.eoc_out = eoc_s;
        if (sclk_rise) begin
            // host bit enters on the same clock that carries the result
            lnk_nxt.shift = {lnk_r.shift[`SSCC_CW_WIDTH-2:0], host_s};
            lnk_nxt.dout = sdata_s;
        end
        if (eoc_rise) begin
            // taken from the next value so a last bit on this edge counts;
            // bits below the kept field are dropped here
            lnk_nxt.word = lnk_nxt.shift[`SSCC_CW_WIDTH-1:`SSCC_CW_KEEP_LSB];
            lnk_nxt.tgl = ~lnk_r.tgl;
        end
    end

    // link-side state; latches start at zero until the first word
    always_ff @(posedge lnk_clk or posedge rst) begin
        if (rst) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    assign data_out = lnk_r.dout;
    assign eoc_out = lnk_r.eoc_out;

    // ---------------- core domain ----------------
    // the toggle announces a new word; the word itself is held steady
    // for a whole conversion, far longer than the two-flop delay
    assign cp_raw[CP_CONV] = conv_clk_pin;
    assign cp_raw[CP_TGL] = lnk_r.tgl;
    generate
        for (gi = 0; gi < CP_N; gi++) begin : g_core_sync
            sscc_sync u_sync (
                .clk(mclk),
                .rst(rst),
                .d(cp_raw[gi]),
                .q(cp_s[gi])
            );
        end
    endgenerate
    assign conv_s = cp_s[CP_CONV];
    assign tgl_s = cp_s[CP_TGL];

    // host conversion clock edge; the host keeps it a square wave
    assign conv_rise = sscc_pkg::sscc_rise(conv_s, core_r.conv_d);
    // start source: halved clock for every-second sampling, else direct
    assign sel = core_r.mode[KW_RATE] ? core_r.half : core_r.conv_d;
    assign sel_rise = sscc_pkg::sscc_rise(sel, core_r.sel_d);

    // sequencing: halving, holder phases, mode capture, settle and start
    always_comb begin
        core_nxt = core_r;
        core_nxt.tgl_d = tgl_s;
        core_nxt.conv_d = conv_s;
        core_nxt.sel_d = sel;
        // converter clock is the local oscillator halved
        core_nxt.osc_div = ~core_r.osc_div;
        // the word is read across domains only after its toggle has passed two flops
        if (tgl_s != core_r.tgl_d) begin
            core_nxt.word = lnk_r.word;
        end
        // gain follows the newest word at once
        core_nxt.att = core_nxt.word[KW_ATT_MSB:KW_ATT_LSB];
        if (conv_rise) begin
            core_nxt.half = ~core_r.half;
            // mode bits only change as a new right/left pair begins,
            // so a switch never splits a pair; 11 samples as 01 and also sets filter bypass
            if (!core_r.half) begin
                core_nxt.mode = core_nxt.word[KW_BYPASS:KW_RATE];
                core_nxt.bypass = core_nxt.word[KW_BYPASS];
            end
        end
        // holders in anti-phase, the holding one routed to the converter;
        // mono changes none of this
        core_nxt.hold_r = core_nxt.half;
        core_nxt.hold_l = ~core_nxt.half;
        core_nxt.mux_r = core_nxt.half;
        // settle delay then a one-cycle start; edges while busy are
        // ignored, harmless since clock periods exceed the delay
        case (core_r.st)
            sscc_pkg::SSCC_ST_IDLE: begin
                if (sel_rise) begin
                    core_nxt.st = sscc_pkg::SSCC_ST_SETTLE;
                    core_nxt.cnt = 5'(`SSCC_SETTLE_LOAD);
                end
            end
            sscc_pkg::SSCC_ST_SETTLE: begin
                if (core_r.cnt == 5'h00) begin
                    core_nxt.st = sscc_pkg::SSCC_ST_FIRE;
                end else begin
                    core_nxt.cnt = core_r.cnt - 5'h01;
                end
            end
            sscc_pkg::SSCC_ST_FIRE: begin
                core_nxt.st = sscc_pkg::SSCC_ST_IDLE;
            end
            default: begin
                core_nxt.st = sscc_pkg::SSCC_ST_IDLE;
            end
        endcase
        core_nxt.start = (core_nxt.st == sscc_pkg::SSCC_ST_FIRE);
    end

    // core-side state; left holder holds first so the phases differ
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            core_r <= '{
                st: sscc_pkg::SSCC_ST_IDLE,
                hold_l: `SSCC_HOLD_L_RST,
                word: `SSCC_KW_RESET,
                default: '0
            };
        end else begin
            core_r <= core_nxt;
        end
    end

    assign cvt_clk = core_r.osc_div;
    assign conv_start = core_r.start;
    assign hold_right = core_r.hold_r;
    assign hold_left = core_r.hold_l;
    assign mux_right = core_r.mux_r;
    assign gain_atten = core_r.att;
    // the bypass bit drives both the filter relay and the right feed
    assign filter_bypass = core_r.bypass;
    assign right_to_both = core_r.bypass;

    // ---------------- checks ----------------
    AST_HOLD_ANTIPHASE: assert property (@(posedge mclk) disable iff (rst)
        hold_right != hold_left)
        else $error("both holders in the same phase");

    AST_MUX_IS_HOLDER: assert property (@(posedge mclk) disable iff (rst)
        mux_right == hold_right)
        else $error("converter input not on the holding stage");

    AST_HALF_ON_EDGE: assert property (@(posedge mclk) disable iff (rst)
        conv_rise |=> (hold_right != $past(hold_right)))
        else $error("holder phase did not turn on a conversion clock edge");

    AST_HALF_STEADY: assert property (@(posedge mclk) disable iff (rst)
        !conv_rise |=> $stable(hold_right))
        else $error("holder phase turned without a conversion clock edge");

    AST_SETTLE_TIME: assert property (@(posedge mclk) disable iff (rst)
        (core_r.st == sscc_pkg::SSCC_ST_IDLE && sel_rise) |-> ##SETTLE_I conv_start)
        else $error("start pulse not at the settle delay");

    AST_NO_EARLY_START: assert property (@(posedge mclk) disable iff (rst)
        (core_r.st == sscc_pkg::SSCC_ST_IDLE && sel_rise) |=> (!conv_start) [*8])
        else $error("start pulse came before the settle delay");

    AST_START_SINGLE: assert property (@(posedge mclk) disable iff (rst)
        conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");

    AST_MODE_BOUNDARY: assert property (@(posedge mclk) disable iff (rst)
        !$stable(core_r.mode) |-> (hold_right && !$past(hold_right)))
        else $error("mode changed away from a pair boundary");

    AST_MONO_RIGHT: assert property (@(posedge mclk) disable iff (rst)
        (conv_start && core_r.mode[KW_RATE]) |-> hold_right)
        else $error("mono start while the left stage is selected");

    AST_BYPASS_WITH_MODE: assert property (@(posedge mclk) disable iff (rst)
        filter_bypass == core_r.mode[KW_BYPASS])
        else $error("filter bypass out of step with the mode");

    AST_OSC_HALF: assert property (@(posedge mclk) disable iff (rst)
        cvt_clk |=> !cvt_clk)
        else $error("converter clock is not the oscillator halved");

    AST_SHIFT_IN: assert property (@(posedge lnk_clk) disable iff (rst)
        sclk_rise |=> (lnk_r.shift[0] == $past(host_s)))
        else $error("host bit not shifted on the data clock");

    AST_RESULT_OUT: assert property (@(posedge lnk_clk) disable iff (rst)
        sclk_rise |=> (data_out == $past(sdata_s)))
        else $error("result bit not forwarded with its clock");

    AST_LATCH_EOC: assert property (@(posedge lnk_clk) disable iff (rst)
        !eoc_rise |=> $stable(lnk_r.word))
        else $error("control latch moved without end of conversion");

    AST_DCLK_FOLLOWS: assert property (@(posedge lnk_clk) disable iff (rst)
        (sclk_rise && !data_clk) |=> data_clk)
        else $error("data clock not raised by a bit pulse");

    // further core checks: each output against the state that should cause it
    AST_OSC_RISE: assert property (@(posedge mclk) disable iff (rst)
        !cvt_clk |=> cvt_clk)
        else $error("converter clock stuck low");

    AST_LEFT_ON_EDGE: assert property (@(posedge mclk) disable iff (rst)
        conv_rise |=> (hold_left != $past(hold_left)))
        else $error("left holder did not turn on a conversion clock edge");

    AST_GAIN_COPY: assert property (@(posedge mclk) disable iff (rst)
        (tgl_s != core_r.tgl_d) |=> (gain_atten == $past(lnk_r.word[KW_ATT_MSB:KW_ATT_LSB])))
        else $error("gain not taken from the newly latched word");

    AST_RIGHT_BOTH: assert property (@(posedge mclk) disable iff (rst)
        right_to_both == filter_bypass)
        else $error("right feed out of step with the filter bypass");

    // sixteen ticks: one to pass the edge to the selector, fifteen of settle
    AST_DIRECT_START: assert property (@(posedge mclk) disable iff (rst)
        (conv_rise && !core_r.mode[KW_RATE] && core_r.st == sscc_pkg::SSCC_ST_IDLE)
        |-> ##16 conv_start)
        else $error("direct clock edge gave no start");

    AST_START_AFTER_SETTLE: assert property (@(posedge mclk) disable iff (rst)
        conv_start |-> ($past(core_r.st) == sscc_pkg::SSCC_ST_SETTLE))
        else $error("start pulse without a settle period before it");

    AST_BYPASS_BOUNDARY: assert property (@(posedge mclk) disable iff (rst)
        !$stable(filter_bypass) |-> (hold_right && !$past(hold_right)))
        else $error("filter bypass changed away from a pair boundary");

    // further link checks, on the link clock where these signals live
    AST_TGL_ON_EOC: assert property (@(posedge lnk_clk) disable iff (rst)
        eoc_rise |=> (lnk_r.tgl != $past(lnk_r.tgl)))
        else $error("new word not announced to the core");

    AST_WORD_IS_SHIFT: assert property (@(posedge lnk_clk) disable iff (rst)
        eoc_rise |=> (lnk_r.word == lnk_r.shift[`SSCC_CW_WIDTH-1:`SSCC_CW_KEEP_LSB]))
        else $error("latched word differs from the shifted bits");

    AST_EOC_FORWARD: assert property (@(posedge lnk_clk) disable iff (rst)
        eoc_out == $past(eoc_s))
        else $error("end of conversion not passed on to the host");

    // nine link cycles high, then low again
    AST_DCLK_WIDTH: assert property (@(posedge lnk_clk) disable iff (rst)
        (data_clk && !$past(data_clk)) |-> ##8 (data_clk ##1 !data_clk))
        else $error("data clock high time not about half a bit");
endmodule // sscc_top

/* test/sscc_host_model.sv */
// host and converter model facing the sampler's link and conversion pins
`timescale 1ns/100ps
module sscc_host_model #(
    parameter int CONV_HALF = 150
) (
    input wire logic mclk,
    input wire logic lnk_clk,
    input wire logic conv_start,
    input wire logic data_clk,
    input wire logic data_out,
    input wire logic eoc_out,
    input wire logic [15:0] ctl_word,
    output logic conv_clk_pin,
    output logic host_sdata_pin,
    output logic cvt_sclk_pin,
    output logic cvt_sdata_pin,
    output logic cvt_eoc_pin,
    output logic [15:0] rx_word,
    output logic [15:0] sent_word,
    output logic [7:0] nbits,
    output logic [7:0] hi_last
);
    logic [15:0] res_r;
    logic [15:0] rx_r;
    logic [7:0] nb_r;
    logic [7:0] base_r;
    logic [7:0] hi_r;
    logic armed;

    // pins idle low at time zero; result seed is arbitrary
    initial begin
        conv_clk_pin = 1'b0;
        host_sdata_pin = 1'b0;
        cvt_sclk_pin = 1'b0;
        cvt_sdata_pin = 1'b0;
        cvt_eoc_pin = 1'b0;
        res_r = 16'hC35A;
        rx_r = 16'h0000;
        nb_r = 8'h00;
        base_r = 8'h00;
        hi_r = 8'h00;
        armed = 1'b0;
        hi_last = 8'h00;
    end

    // wait link edges, then move just after the edge
    task automatic lk(input int n);
        repeat (n) @(posedge lnk_clk);
        #1;
    endtask

    // square conversion clock whose rising edges request starts
    always begin
        repeat (CONV_HALF) @(posedge mclk);
        #1 conv_clk_pin = ~conv_clk_pin;
    end

    // converter: 15 full bit clocks then a short one, host bits ride the same clock
    always begin
        @(posedge conv_start);
        for (int i = 15; i >= 0; i--) begin
            lk(1);
            cvt_sdata_pin = res_r[i];
            host_sdata_pin = ctl_word[i]; // msb first
            lk(9);
            cvt_sclk_pin = 1'b1;
            lk((i == 0) ? 3 : 10); // last pulse only about 100 ns
            cvt_sclk_pin = 1'b0;
        end
        lk(14);
        sent_word = res_r;
        cvt_eoc_pin = 1'b1;
        lk(4);
        cvt_eoc_pin = 1'b0;
        // released lines show the inverse of their last level, not a held value
        cvt_sdata_pin = ~cvt_sdata_pin;
        host_sdata_pin = ~host_sdata_pin;
        res_r = res_r + 16'h1357;
    end

    // host shifts result bits on a true data clock fall; the unknown-to-low
    // step at start-up is no bit and must not be counted
    always @(data_clk) begin
        if (data_clk === 1'b1) begin
            armed <= 1'b1;
        end else if (data_clk === 1'b0 && armed) begin
            rx_r <= {rx_r[14:0], data_out};
            nb_r <= nb_r + 8'h01;
            armed <= 1'b0;
        end
    end

    // host latches the received word on end of conversion
    always @(posedge eoc_out) begin
        rx_word <= rx_r;
        nbits <= nb_r - base_r;
        base_r <= nb_r;
    end

    // high time of each data clock pulse in link cycles
    always @(posedge lnk_clk) begin
        if (data_clk === 1'b1) begin
            hi_r <= hi_r + 8'h01;
        end else if (hi_r != 8'h00) begin
            hi_last <= hi_r;
            hi_r <= 8'h00;
        end
    end
endmodule // sscc_host_model

/* test/sscc_top_bench.sv */
// self-checking bench of the sampler conversion control
`timescale 1ns/100ps
module sscc_top_bench;
    localparam int LIMIT = 40000;
    logic mclk = 1'b0;
    logic lnk_clk = 1'b0;
    logic rst = 1'b1;
    logic conv_clk_pin, host_sdata_pin, cvt_sclk_pin, cvt_sdata_pin, cvt_eoc_pin;
    logic data_clk, data_out, eoc_out, cvt_clk, conv_start;
    logic hold_right, hold_left, mux_right, filter_bypass, right_to_both;
    logic [7:0] gain_atten;
    logic [15:0] ctl = 16'h0000;
    logic [15:0] rx_word, sent_word, starts;
    logic [7:0] nbits, hi_last;
    logic run = 1'b0;
    logic mono = 1'b0;
    logic hr_prev = 1'b0;
    logic fb_prev = 1'b0;
    logic cvt_prev = 1'b0;
    logic [15:0] words [4] = '{16'hA53F, 16'h3C55, 16'h5A80, 16'h9629};
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    // core clock 100 ns; link clock 30 ns with a phase offset
    always #50 mclk = ~mclk;
    initial begin
        #3.7;
        forever #15 lnk_clk = ~lnk_clk;
    end

    sscc_top sscc_top_i (
        .mclk(mclk), .rst(rst), .lnk_clk(lnk_clk), .conv_clk_pin(conv_clk_pin),
        .host_sdata_pin(host_sdata_pin), .cvt_sclk_pin(cvt_sclk_pin),
        .cvt_sdata_pin(cvt_sdata_pin), .cvt_eoc_pin(cvt_eoc_pin), .data_clk(data_clk),
        .data_out(data_out), .eoc_out(eoc_out), .cvt_clk(cvt_clk), .conv_start(conv_start),
        .hold_right(hold_right), .hold_left(hold_left), .mux_right(mux_right),
        .gain_atten(gain_atten), .filter_bypass(filter_bypass), .right_to_both(right_to_both)
    );

    sscc_host_model sscc_host_model_i (
        .mclk(mclk), .lnk_clk(lnk_clk), .conv_start(conv_start), .data_clk(data_clk),
        .data_out(data_out), .eoc_out(eoc_out), .ctl_word(ctl), .conv_clk_pin(conv_clk_pin),
        .host_sdata_pin(host_sdata_pin), .cvt_sclk_pin(cvt_sclk_pin),
        .cvt_sdata_pin(cvt_sdata_pin), .cvt_eoc_pin(cvt_eoc_pin), .rx_word(rx_word),
        .sent_word(sent_word), .nbits(nbits), .hi_last(hi_last)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard: the four mode rows need well under this many cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            finish_test();
        end
    end

    // settled-value monitor at the falling edge, away from the launching edge
    always @(negedge mclk) begin
        if (run) begin
            check(hold_left, !hold_right);
            check(mux_right, hold_right);
            check(right_to_both, filter_bypass);
            check(cvt_clk, !cvt_prev);
            if (filter_bypass !== fb_prev) begin
                check({hold_right, hr_prev}, 2'h2);
            end
            if (conv_start === 1'b1) begin
                starts = starts + 16'h0001;
                if (mono) begin
                    check(hold_right, 1'b1);
                end
            end
        end
        hr_prev = hold_right;
        fb_prev = filter_bypass;
        cvt_prev = cvt_clk;
    end

    // every result word reaches the host whole, with 16 stretched clocks
    always @(negedge eoc_out) begin
        if (run) begin
            check(rx_word, sent_word);
            check(nbits, 8'h10);
            check(hi_last, 8'h09);
        end
    end

    initial begin
        starts = 16'h0000;
        repeat (3) @(posedge mclk);
        check({data_clk, data_out, eoc_out, cvt_clk, conv_start, hold_right, hold_left,
               mux_right, filter_bypass, right_to_both}, 10'h008);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        run = 1'b1;
        check(gain_atten, 8'h00);
        // each row: send a word, wait for the pair boundary, then count starts
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk);
            #1 ctl = words[k];
            // old mono flag is void once the next pair boundary may switch modes
            mono = 1'b0;
            @(posedge eoc_out);
            @(posedge eoc_out);
            repeat (10) @(negedge mclk);
            check(gain_atten, ctl[15:8]);
            repeat (3) @(posedge conv_clk_pin);
            @(negedge mclk);
            check(filter_bypass, ctl[7]);
            mono = ctl[6];
            @(posedge conv_clk_pin);
            starts = 16'h0000;
            repeat (4) @(posedge conv_clk_pin);
            check(starts, ctl[6] ? 16'h0002 : 16'h0004);
            if (!ctl[6]) begin
                @(posedge conv_clk_pin);
                n = 0;
                while (conv_start !== 1'b1 && n < 40) begin
                    @(negedge mclk);
                    n++;
                end
                check(n >= 15 && n <= 19, 1'b1);
            end
        end
        finish_test();
    end
endmodule // sscc_top_bench
